/* src/fbm_pkg.sv */
/*
  shared constants, register map and state types of the frame buffer manager.
  assumes a single 25 MHz clock domain.
*/
package fbm_pkg;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_IN_RATE  = 8'h08;
  localparam logic [7:0]  REG_OUT_RATE = 8'h0c;
  localparam logic [7:0]  REG_DELAY    = 8'h10;
  localparam logic [7:0]  REG_FLEN     = 8'h14;
  localparam logic [7:0]  REG_DROPS    = 8'h18;
  localparam logic [7:0]  REG_REPEATS  = 8'h1c;
  localparam int          CTRL_GO      = 0;
  localparam int          CTRL_AFFIN   = 1;
  localparam int          CTRL_DROP    = 2;
  localparam int          CTRL_REPEAT  = 3;
  localparam int          CTRL_SYNC    = 4;
  localparam int          CTRL_W       = 5;
  localparam logic [4:0]  CTRL_RESET   = 5'h00;
  localparam logic [15:0] RATE_RESET   = 16'h0001;
  localparam logic [11:0] DELAY_RESET  = 12'h000;
  localparam logic [11:0] DELAY_MAX    = 12'hfff;
  localparam logic [3:0]  TYPE_IMAGE   = 4'h0;
  localparam logic [3:0]  TYPE_CTRL    = 4'hf;
  localparam int          TYPE_W       = 4;
  localparam int          DIM_W        = 16;
  localparam logic [1:0]  BUF0         = 2'h0;
  localparam logic [1:0]  BUF1         = 2'h1;
  localparam logic [1:0]  BUF2         = 2'h2;
  localparam int          NBUF         = 3;
  typedef enum logic [1:0] {W_RUN, W_MEM, W_DEC} wstate_e;
  typedef enum logic [1:0] {R_WAIT, R_REQ, R_DATA, R_OUT} rstate_e;
  typedef enum logic [2:0] {ACT_NONE, ACT_SWAP, ACT_RESTART, ACT_REPEAT, ACT_DSWAP} act_e;
endpackage

/* src/video_frame_buffer_manager.sv */
/*
  frame buffer manager: writer stores a packet video stream into external memory,
  reader plays frames back; double/triple buffering, drop/repeat, locked rate.
  assumes ahb-lite master, same-clock stream partners and a word-addressed memory.
*/
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module video_frame_buffer_manager
  import fbm_pkg::*;
#(
  parameter int PIX_W        = 40,
  parameter int PIXELS       = 1,
  parameter int MEM_AW       = 32,
  parameter int BUF_WORDS    = 32'h0010_0000,
  parameter int MAX_ANC      = 2,
  parameter int ANC_WORDS    = 16,
  parameter bit HAS_WRITER   = 1'b1,
  parameter bit HAS_READER   = 1'b1,
  parameter bit DROP_INVALID = 1'b0
)(
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         hsel_in,
  input  wire logic [31:0]                  haddr_in,
  input  wire logic [1:0]                   htrans_in,
  input  wire logic                         hwrite_in,
  input  wire logic [2:0]                   hsize_in,
  input  wire logic [31:0]                  hwdata_in,
  input  wire logic                         hready_in,
  output logic                              hreadyout_out,
  output logic                              hresp_out,
  output logic [31:0]                       hrdata_out,
  input  wire logic                         din_valid_in,
  output logic                              din_ready_out,
  input  wire logic [PIXELS*PIX_W-1:0]      din_data_in,
  input  wire logic                         din_sop_in,
  input  wire logic                         din_eop_in,
  output logic                              dout_valid_out,
  input  wire logic                         dout_ready_in,
  output logic [PIXELS*PIX_W-1:0]           dout_data_out,
  output logic                              dout_sop_out,
  output logic                              dout_eop_out,
  output logic                              mem_wr_valid_out,
  input  wire logic                         mem_wr_ready_in,
  output logic [MEM_AW-1:0]                 mem_wr_addr_out,
  output logic [PIXELS*PIX_W+1:0]           mem_wr_data_out,
  output logic                              mem_rd_req_out,
  input  wire logic                         mem_rd_ack_in,
  output logic [MEM_AW-1:0]                 mem_rd_addr_out,
  input  wire logic                         mem_rd_valid_in,
  input  wire logic [PIXELS*PIX_W+1:0]      mem_rd_data_in
);
  localparam int DW = PIXELS * PIX_W;
  localparam int FRAME_OFS = MAX_ANC * ANC_WORDS;

  function automatic logic [MEM_AW-1:0] word_addr(input logic [1:0] b, input int ofs);
    word_addr = MEM_AW'(int'(b) * BUF_WORDS + ofs);
  endfunction

  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       in_rate;
  logic [15:0]       out_rate;
  logic [11:0]       delay;
  logic [31:0]       flen_reg;
  logic [15:0]       drops;
  logic [15:0]       repeats;
  logic              wpend;
  logic              rpend;
  logic [7:0]        req_addr;
  logic [1:0]        wbuf;
  logic [1:0]        rbuf;
  logic [1:0]        sbuf;
  logic              spare_clean;
  logic              rbuf_valid;
  logic [11:0]       frames_written;
  logic [31:0]       flen [NBUF];
  logic [16:0]       rate_acc;
  logic [7:0]        anc_cnt [NBUF];
  logic [7:0]        anc_head [NBUF];
  logic [15:0]       anc_len [NBUF*MAX_ANC];
  wstate_e           wstate;
  rstate_e           rstate;
  act_e              w_act;
  act_e              r_act;
  logic [3:0]        w_type;
  logic [31:0]       w_pidx;
  logic [31:0]       w_fidx;
  logic              w_last;
  logic              w_bad;
  logic              ctl_seen;
  logic [31:0]       exp_beats;
  logic [7:0]        r_anc_left;
  logic [7:0]        r_slot;
  logic [31:0]       r_idx;

  wire        wr_go   = ctrl[CTRL_GO] && HAS_WRITER;
  wire        triple  = ctrl[CTRL_DROP] || ctrl[CTRL_REPEAT] || ctrl[CTRL_SYNC];
  wire        aff     = ctrl[CTRL_AFFIN] && DROP_INVALID;
  wire [16:0] acc_sum = rate_acc + 17'(in_rate);
  wire        accept  = din_valid_in && din_ready_out;
  wire [3:0]  cur_t   = din_sop_in ? din_data_in[TYPE_W-1:0] : w_type;
  wire        cur_anc = cur_t != TYPE_IMAGE && cur_t != TYPE_CTRL;
  wire [31:0] cur_idx = din_sop_in ? 32'h0000_0000 : w_pidx + 32'h0000_0001;
  wire        store   = !cur_anc || cur_idx < 32'(ANC_WORDS);
  wire        delay_ok = frames_written >= delay;
  wire [31:0] r_flen  = HAS_WRITER ? flen[rbuf] : flen_reg;
  wire [31:0] r_limit = r_anc_left != 8'h00 ? 32'(anc_len[int'(rbuf) * MAX_ANC + int'(r_slot)])
                                             : r_flen;
  wire        r_last  = r_idx + 32'h0000_0001 >= r_limit;
  wire [1:0]  pick_buf = r_act == ACT_SWAP ? sbuf : (w_act == ACT_DSWAP ? wbuf : rbuf);

  ////////////////////////////////////////////////////////////////////////////////
  // register slave: writes zero wait, reads one wait state

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wpend         <= 1'b0;
      rpend         <= 1'b0;
      req_addr      <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= 32'h0000_0000;
    end
    else
    begin
      wpend     <= 1'b0;
      rpend     <= 1'b0;
      hresp_out <= 1'b0;
      if (hsel_in && htrans_in[1] && hready_in)
      begin
        req_addr      <= haddr_in[7:0];
        wpend         <= hwrite_in;
        rpend         <= !hwrite_in;
        hreadyout_out <= hwrite_in;
      end
      if (rpend)
      begin
        hreadyout_out <= 1'b1;
        unique case (req_addr)
          REG_CTRL:     hrdata_out <= 32'(ctrl);
          REG_STATUS:   hrdata_out <= {22'h00_0000, rstate == R_WAIT, wstate == W_DEC,
                                       rbuf_valid, spare_clean, sbuf, rbuf, wbuf};
          REG_IN_RATE:  hrdata_out <= 32'(in_rate);
          REG_OUT_RATE: hrdata_out <= 32'(out_rate);
          REG_DELAY:    hrdata_out <= 32'(delay);
          REG_FLEN:     hrdata_out <= flen_reg;
          REG_DROPS:    hrdata_out <= 32'(drops);
          REG_REPEATS:  hrdata_out <= 32'(repeats);
          default:      hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl     <= CTRL_RESET;
      in_rate  <= RATE_RESET;
      out_rate <= RATE_RESET;
      delay    <= DELAY_RESET;
      flen_reg <= 32'h0000_0000;
    end
    else if (wpend)
    begin
      unique case (req_addr)
        REG_CTRL:     ctrl <= hwdata_in[CTRL_W-1:0];
        REG_IN_RATE:  in_rate <= hwdata_in[15:0];
        REG_OUT_RATE: out_rate <= hwdata_in[15:0];
        REG_DELAY:    delay <= hwdata_in[11:0];
        REG_FLEN:     flen_reg <= hwdata_in;
        default:      ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer exchange decisions; the writer side has priority

  always_comb
  begin
    w_act = ACT_NONE;
    r_act = ACT_NONE;
    if (wstate == W_DEC)
    begin
      if (DROP_INVALID && w_bad)
        w_act = ACT_RESTART;
      else if (!triple)
      begin
        if (rstate == R_WAIT || !HAS_READER)
          w_act = ACT_DSWAP;
      end
      else if (ctrl[CTRL_SYNC] || !spare_clean || !HAS_READER)
        w_act = ACT_SWAP;
      else if (ctrl[CTRL_DROP])
        w_act = ACT_RESTART;
    end
    // reader acts only in cycles where the writer does not, so a stalled writer is freed
    if (w_act == ACT_NONE && rstate == R_WAIT && ctrl[CTRL_GO] && HAS_READER && delay_ok)
    begin
      if (!HAS_WRITER)
        r_act = ACT_REPEAT;
      else if (!triple)
        r_act = ACT_NONE;
      else if (ctrl[CTRL_SYNC])
      begin
        if (acc_sum >= 17'(out_rate) && spare_clean)
          r_act = ACT_SWAP;
        else if (rbuf_valid)
          r_act = ACT_REPEAT;
      end
      else if (spare_clean)
        r_act = ACT_SWAP;
      else if (ctrl[CTRL_REPEAT] && rbuf_valid)
        r_act = ACT_REPEAT;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wbuf           <= BUF0;
      rbuf           <= BUF1;
      sbuf           <= BUF2;
      spare_clean    <= 1'b0;
      rbuf_valid     <= 1'b0;
      frames_written <= 12'h000;
      drops          <= 16'h0000;
      repeats        <= 16'h0000;
      rate_acc       <= 17'h0_0000;
      flen           <= '{default: 32'h0000_0000};
    end
    else
    begin
      if (wstate == W_DEC)
        flen[wbuf] <= w_fidx;
      if (w_act != ACT_NONE && frames_written != DELAY_MAX)
        frames_written <= frames_written + 12'h001;
      unique case (w_act)
        ACT_SWAP:
        begin
          wbuf        <= sbuf;
          sbuf        <= wbuf;
          spare_clean <= 1'b1;
          if (spare_clean)
            drops <= drops + 16'h0001;
        end
        ACT_DSWAP:
        begin
          wbuf       <= rbuf;
          rbuf       <= wbuf;
          rbuf_valid <= 1'b1;
        end
        ACT_RESTART: drops <= drops + 16'h0001;
        default: ;
      endcase
      unique case (r_act)
        ACT_SWAP:
        begin
          rbuf        <= sbuf;
          sbuf        <= rbuf;
          spare_clean <= 1'b0;
          rbuf_valid  <= 1'b1;
          if (ctrl[CTRL_SYNC])
            rate_acc <= acc_sum - 17'(out_rate);
        end
        ACT_REPEAT:
        begin
          repeats <= repeats + 16'h0001;
          if (ctrl[CTRL_SYNC])
            rate_acc <= acc_sum;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writer

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wstate           <= W_RUN;
      din_ready_out    <= 1'b0;
      mem_wr_valid_out <= 1'b0;
      mem_wr_addr_out  <= '0;
      mem_wr_data_out  <= '0;
      w_type           <= TYPE_IMAGE;
      w_pidx           <= 32'h0000_0000;
      w_fidx           <= 32'h0000_0000;
      w_last           <= 1'b0;
      w_bad            <= 1'b0;
      ctl_seen         <= 1'b0;
      exp_beats        <= 32'h0000_0000;
      anc_cnt          <= '{default: 8'h00};
      anc_head         <= '{default: 8'h00};
      anc_len          <= '{default: 16'h0000};
    end
    else
    begin
      unique case (wstate)
        W_RUN:
        begin
          din_ready_out <= wr_go;
          if (accept)
          begin
            w_type <= cur_t;
            w_pidx <= cur_idx;
            w_last <= din_eop_in && cur_t == TYPE_IMAGE;
            if (cur_t == TYPE_CTRL && cur_idx == 32'h0000_0001)
            begin
              ctl_seen  <= 1'b1;
              exp_beats <= 32'(din_data_in[DIM_W-1:0] * din_data_in[2*DIM_W-1:DIM_W]) / PIXELS;
            end
            if (din_eop_in && cur_t == TYPE_IMAGE)
              w_bad <= ctl_seen && cur_idx != exp_beats;
            if (cur_anc && din_eop_in && MAX_ANC > 0)
            begin
              anc_len[int'(wbuf) * MAX_ANC + int'(anc_head[wbuf])] <=
                store ? 16'(cur_idx + 32'h0000_0001) : 16'(ANC_WORDS);
              anc_head[wbuf] <= anc_head[wbuf] + 8'h01 == 8'(MAX_ANC) ? 8'h00
                                : anc_head[wbuf] + 8'h01;
              if (anc_cnt[wbuf] != 8'(MAX_ANC))
                anc_cnt[wbuf] <= anc_cnt[wbuf] + 8'h01;
            end
            if (store && !(cur_anc && MAX_ANC == 0))
            begin
              din_ready_out    <= 1'b0;
              mem_wr_valid_out <= 1'b1;
              mem_wr_data_out  <= {din_sop_in,
                                   din_eop_in || (cur_anc && cur_idx == 32'(ANC_WORDS - 1)),
                                   din_data_in};
              mem_wr_addr_out  <= cur_anc
                ? word_addr(wbuf, int'(anc_head[wbuf]) * ANC_WORDS + int'(cur_idx))
                : word_addr(wbuf, FRAME_OFS + int'(w_fidx));
              if (!cur_anc)
                w_fidx <= w_fidx + 32'h0000_0001;
              wstate <= W_MEM;
            end
          end
        end
        W_MEM:
        begin
          if (mem_wr_ready_in)
          begin
            mem_wr_valid_out <= 1'b0;
            din_ready_out    <= wr_go && !w_last;
            wstate           <= w_last ? W_DEC : W_RUN;
          end
        end
        W_DEC:
        begin
          if (w_act != ACT_NONE)
          begin
            wstate        <= W_RUN;
            din_ready_out <= wr_go;
            w_fidx        <= 32'h0000_0000;
            w_last        <= 1'b0;
            w_bad         <= 1'b0;
            ctl_seen      <= 1'b0;
            if (w_act == ACT_SWAP)
            begin
              anc_cnt[sbuf]  <= 8'h00;
              anc_head[sbuf] <= 8'h00;
            end
            else if (w_act == ACT_DSWAP)
            begin
              anc_cnt[rbuf]  <= 8'h00;
              anc_head[rbuf] <= 8'h00;
            end
            else if (aff)
            begin
              anc_cnt[wbuf]  <= 8'h00;
              anc_head[wbuf] <= 8'h00;
            end
          end
        end
        default: wstate <= W_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reader

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rstate          <= R_WAIT;
      mem_rd_req_out  <= 1'b0;
      mem_rd_addr_out <= '0;
      dout_valid_out  <= 1'b0;
      dout_data_out   <= '0;
      dout_sop_out    <= 1'b0;
      dout_eop_out    <= 1'b0;
      r_anc_left      <= 8'h00;
      r_slot          <= 8'h00;
      r_idx           <= 32'h0000_0000;
    end
    else
    begin
      unique case (rstate)
        R_WAIT:
        begin
          if (r_act != ACT_NONE || (w_act == ACT_DSWAP && HAS_READER))
          begin
            rstate <= R_REQ;
            r_idx  <= 32'h0000_0000;
            r_anc_left <= (r_act == ACT_REPEAT && !aff) ? 8'h00 : anc_cnt[pick_buf];
            r_slot     <= anc_cnt[pick_buf] == 8'(MAX_ANC) ? anc_head[pick_buf] : 8'h00;
          end
        end
        R_REQ:
        begin
          if (!mem_rd_req_out)
          begin
            mem_rd_req_out  <= 1'b1;
            mem_rd_addr_out <= r_anc_left != 8'h00
              ? word_addr(rbuf, int'(r_slot) * ANC_WORDS + int'(r_idx))
              : word_addr(rbuf, FRAME_OFS + int'(r_idx));
          end
          else if (mem_rd_ack_in)
          begin
            mem_rd_req_out <= 1'b0;
            rstate         <= R_DATA;
          end
        end
        R_DATA:
        begin
          if (mem_rd_valid_in)
          begin
            dout_valid_out <= 1'b1;
            {dout_sop_out, dout_eop_out, dout_data_out} <= mem_rd_data_in;
            rstate         <= R_OUT;
          end
        end
        R_OUT:
        begin
          if (dout_ready_in)
          begin
            dout_valid_out <= 1'b0;
            r_idx          <= r_last ? 32'h0000_0000 : r_idx + 32'h0000_0001;
            rstate         <= (r_last && r_anc_left == 8'h00) ? R_WAIT : R_REQ;
            if (r_last && r_anc_left != 8'h00)
            begin
              r_anc_left <= r_anc_left - 8'h01;
              r_slot     <= r_slot + 8'h01 == 8'(MAX_ANC) ? 8'h00 : r_slot + 8'h01;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_beat_taken;
    wstate == W_RUN && accept && store && !cur_anc;
  endsequence
  sequence s_beat_stored;
    mem_wr_valid_out && wstate == W_MEM;
  endsequence
  property p_write_beat;
    @(posedge clk_in) disable iff (rst_in) s_beat_taken |=> s_beat_stored;
  endproperty
  a_write_beat: assert property (p_write_beat) else $error("beat not written");
  property p_bufs_distinct;
    @(posedge clk_in) disable iff (rst_in) wbuf != rbuf && wbuf != sbuf && rbuf != sbuf;
  endproperty
  a_bufs_distinct: assert property (p_bufs_distinct) else $error("buffers alias");
  property p_double_wait;
    @(posedge clk_in) disable iff (rst_in)
      wstate == W_DEC && !triple && !w_bad && rstate != R_WAIT && HAS_READER
      |=> wstate == W_DEC && $stable(wbuf);
  endproperty
  a_double_wait: assert property (p_double_wait) else $error("early swap");
  property p_wswap_clean;
    @(posedge clk_in) disable iff (rst_in)
      w_act == ACT_SWAP |=> spare_clean && sbuf == $past(wbuf);
  endproperty
  a_wswap_clean: assert property (p_wswap_clean) else $error("spare not clean");
  property p_drop_same;
    @(posedge clk_in) disable iff (rst_in)
      w_act == ACT_RESTART |=> $stable(wbuf) && wstate == W_RUN && w_fidx == 32'h0000_0000;
  endproperty
  a_drop_same: assert property (p_drop_same) else $error("drop moved buffer");
  property p_writer_stall;
    @(posedge clk_in) disable iff (rst_in)
      wstate == W_DEC && triple && spare_clean && !ctrl[CTRL_DROP] && !ctrl[CTRL_SYNC]
      && !w_bad && HAS_READER |=> wstate == W_DEC;
  endproperty
  a_writer_stall: assert property (p_writer_stall) else $error("writer ran on");
  property p_rswap_dirty;
    @(posedge clk_in) disable iff (rst_in)
      r_act == ACT_SWAP |=> !spare_clean && rbuf == $past(sbuf) ##1 mem_rd_req_out;
  endproperty
  a_rswap_dirty: assert property (p_rswap_dirty) else $error("reader swap bad");
  property p_repeat_same;
    @(posedge clk_in) disable iff (rst_in)
      r_act == ACT_REPEAT |=> $stable(rbuf) && rstate == R_REQ;
  endproperty
  a_repeat_same: assert property (p_repeat_same) else $error("repeat lost frame");
  property p_reader_stall;
    @(posedge clk_in) disable iff (rst_in)
      rstate == R_WAIT && triple && !spare_clean && !ctrl[CTRL_REPEAT] && !ctrl[CTRL_SYNC]
      && HAS_WRITER |=> rstate == R_WAIT;
  endproperty
  a_reader_stall: assert property (p_reader_stall) else $error("reader ran on");
  property p_first_frame;
    @(posedge clk_in) disable iff (rst_in)
      !rbuf_valid && HAS_WRITER |-> rstate == R_WAIT && !dout_valid_out;
  endproperty
  a_first_frame: assert property (p_first_frame) else $error("output before frame");
endmodule

/* test/fbm_mem_model.sv */
/*
  external memory model: word writes, one read at a time, slow and prompt.
  assumes the manager's registered request / held-until-ready contract.
*/
`timescale 1ns/1ns
module fbm_mem_model #(
  parameter int AW = 32,
  parameter int DW = 42
)(
  input  wire logic          clk_in,
  input  wire logic          wr_valid_in,
  output logic               wr_ready_out = 1'b0,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  input  wire logic          rd_req_in,
  output logic               rd_ack_out = 1'b0,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic               rd_valid_out = 1'b0,
  output logic [DW-1:0]      rd_data_out = '0
);
  logic [DW-1:0] mem [256];
  logic          pend = 1'b0;
  logic [AW-1:0] pa;
  ////////////////////////////////////////
  always @(posedge clk_in)
  begin
    wr_ready_out <= ~wr_ready_out; // alternately slow and prompt
    if (wr_valid_in && wr_ready_out)
      mem[wr_addr_in[7:0]] <= wr_data_in;
    rd_ack_out <= rd_req_in && !rd_ack_out && !pend;
    if (pend)
      pend <= 1'b0;
    if (rd_req_in && rd_ack_out)
    begin
      pend <= 1'b1;
      pa <= rd_addr_in;
    end
    rd_valid_out <= pend;
    rd_data_out <= pend ? mem[pa[7:0]] : ~rd_data_out; // stale data never reads stable
  end
endmodule

/* test/video_frame_buffer_manager_bench.sv */
/*
  bench: register reset values, two frames through double buffering, one frame
  through triple buffering with the reader stall, then a reset in mid-run.
  assumes fbm_mem_model stands in for external memory.
*/
`timescale 1ns/1ns
module video_frame_buffer_manager_bench;
  import fbm_pkg::*;
  logic        clk_in = 0, rst_in = 1, hwrite = 0, hready, hresp;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, wa, rda;
  logic        dv = 0, dr, ds = 0, de = 0, ov, ordy = 1, os, oe;
  logic        wv, wr, rq, ra, rv;
  logic [39:0] dd = 0, od;
  logic [41:0] wd, rd, exp_q[$];
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  ra_t[5] = '{REG_CTRL, REG_IN_RATE, REG_OUT_RATE, REG_DELAY, 8'h40};
  logic [31:0] rv_t[5] = '{32'h0, {16'h0, RATE_RESET}, {16'h0, RATE_RESET}, 32'h0, 32'h0};
  video_frame_buffer_manager #(.BUF_WORDS(64)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .din_valid_in(dv), .din_ready_out(dr),
    .din_data_in(dd), .din_sop_in(ds), .din_eop_in(de), .dout_valid_out(ov),
    .dout_ready_in(ordy), .dout_data_out(od), .dout_sop_out(os), .dout_eop_out(oe),
    .mem_wr_valid_out(wv), .mem_wr_ready_in(wr), .mem_wr_addr_out(wa),
    .mem_wr_data_out(wd), .mem_rd_req_out(rq), .mem_rd_ack_in(ra),
    .mem_rd_addr_out(rda), .mem_rd_valid_in(rv), .mem_rd_data_in(rd));
  fbm_mem_model mem (.clk_in(clk_in), .wr_valid_in(wv), .wr_ready_out(wr),
    .wr_addr_in(wa), .wr_data_in(wd), .rd_req_in(rq), .rd_ack_out(ra),
    .rd_addr_in(rda), .rd_valid_out(rv), .rd_data_out(rd));
  ////////////////////////////////////////
  task chk(input logic [41:0] s, input logic [41:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task send(input logic s, input logic e, input logic [39:0] d);
    dv <= 1'b1;
    ds <= s;
    de <= e;
    dd <= d;
    exp_q.push_back({s, e, d});
    do @(posedge clk_in); while (dr !== 1'b1);
  endtask
  ////////////////////////////////////////
  initial
    forever #20 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    ordy <= ~ordy; // downstream stalls every other cycle
    if (ov === 1'b1 && ordy === 1'b1)
      chk({os, oe, od}, exp_q.pop_front());
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({41'h0, dr}, 42'h0);
    chk({41'h0, ov}, 42'h0);
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b0, ra_t[i], 32'h0);
      chk({10'h0, q}, {10'h0, rv_t[i]});
    end
    ahb(1'b1, REG_CTRL, 32'h0000_0001);
    for (int f = 1; f < 3; f++)
    begin
      send(1'b1, 1'b0, 40'h00_0000_0000);
      send(1'b0, 1'b0, 40'(f * 16 + 1));
      send(1'b0, 1'b1, 40'(f * 16 + 2));
    end
    dv <= 1'b0;
    while (exp_q.size() != 0)
      @(posedge clk_in);
    repeat (60) @(posedge clk_in);
    chk({41'h0, ov}, 42'h0);
    ahb(1'b0, REG_DROPS, 32'h0);
    chk({10'h0, q}, 42'h0);
    chk({41'h0, hresp}, 42'h0);
    ahb(1'b1, REG_CTRL, 32'h0000_0005);
    send(1'b1, 1'b0, 40'h00_0000_0000);
    send(1'b0, 1'b0, 40'h00_0000_0031);
    send(1'b0, 1'b1, 40'h00_0000_0032);
    dv <= 1'b0;
    while (exp_q.size() != 0)
      @(posedge clk_in);
    repeat (60) @(posedge clk_in);
    chk({41'h0, ov}, 42'h0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk({10'h0, q}, 42'h000_0000_0292);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({41'h0, dr}, 42'h0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk({10'h0, q}, 42'h000_0000_0224);
    finish_test;
  end
endmodule
